// [design/pms_pkg.sv]
// Package of the management register space: offsets, field positions,
// defaults and state codes. Assumes a single 20 MHz management core clock.
package pms_pkg;

  // ----------------------------------------------------------------------
  // Serial frame constants
  // ----------------------------------------------------------------------
  localparam int unsigned   PMS_PREAMBLE_LEN = 32;
  localparam logic [5:0]    PMS_PREAMBLE_CNT = 6'h20;
  localparam logic [4:0]    PMS_HDR_LAST     = 5'h0c;
  localparam logic [4:0]    PMS_WR_LAST      = 5'h11;
  localparam logic [4:0]    PMS_RD_LAST      = 5'h11;
  localparam logic [1:0]    PMS_OP_READ      = 2'h2;
  localparam logic [1:0]    PMS_OP_WRITE     = 2'h1;
  localparam logic [4:0]    PMS_PHY_ADDR_DEF = 5'h00;

  // ----------------------------------------------------------------------
  // Standard space
  // ----------------------------------------------------------------------
  localparam int unsigned   PMS_STD_REGS     = 32;
  localparam logic [4:0]    PMS_REG_BASIC    = 5'h00;
  localparam logic [4:0]    PMS_REG_IEEE_TOP = 5'h0f;
  localparam logic [4:0]    PMS_REG_MMD_CTL  = 5'h0d;
  localparam logic [4:0]    PMS_REG_MMD_DAT  = 5'h0e;

  // Basic control field positions
  localparam int unsigned   PMS_B_RESET      = 15;
  localparam int unsigned   PMS_B_LOOP       = 14;
  localparam int unsigned   PMS_B_SPEED      = 13;
  localparam int unsigned   PMS_B_ANEN       = 12;
  localparam int unsigned   PMS_B_PDOWN      = 11;
  localparam int unsigned   PMS_B_ISO        = 10;
  localparam int unsigned   PMS_B_ANRST      = 9;
  localparam int unsigned   PMS_B_DUPLEX     = 8;
  localparam int unsigned   PMS_B_COLTEST    = 7;
  localparam logic [15:0]   PMS_BASIC_RW_MSK = 16'h7d80;
  localparam logic [15:0]   PMS_BASIC_RST    = 16'h0000;

  // ----------------------------------------------------------------------
  // Indirect device spaces
  // ----------------------------------------------------------------------
  localparam int unsigned   PMS_MMD_FN_HI    = 15;
  localparam int unsigned   PMS_MMD_FN_LO    = 14;
  localparam logic [1:0]    PMS_FN_ADDR      = 2'h0;
  localparam logic [1:0]    PMS_FN_DATA      = 2'h1;
  localparam logic [1:0]    PMS_FN_INC_RW    = 2'h2;
  localparam logic [1:0]    PMS_FN_INC_WR    = 2'h3;
  localparam logic [4:0]    PMS_DEV_EEE      = 5'h07;
  localparam logic [4:0]    PMS_DEV_WOL      = 5'h1f;
  localparam logic [15:0]   PMS_EEE_ADV      = 16'h003c;
  localparam logic [15:0]   PMS_EEE_LP_ADV   = 16'h003d;
  localparam int unsigned   PMS_WOL_WORDS    = 28;
  localparam logic [15:0]   PMS_WOL_LAST     = 16'h001b;
  localparam logic [15:0]   PMS_WOL_PKT_LO   = 16'h0001;
  localparam logic [15:0]   PMS_WOL_PKT_HI   = 16'h0018;
  localparam logic [15:0]   PMS_WOL_DA_LO    = 16'h0019;
  localparam logic [15:0]   PMS_EEE_ADV_RST  = 16'h0000;

  // Cycles between reset release and strap capture
  localparam logic [1:0]    PMS_LOAD_WAIT    = 2'h3;

  typedef enum logic [1:0] {
    PMS_S_PRE,
    PMS_S_HDR,
    PMS_S_RD,
    PMS_S_WR
  } pms_frame_state_type;

endpackage

// [design/pms_mgmt_if.sv]
// Interface carrying register requests from the frame engine to the bank.
// Assumes both ends on the same core clock.
`timescale 1ns/1ps
interface pms_mgmt_if;
  logic        rd;
  logic        wr;
  logic [4:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;

  modport engine (output rd, output wr, output addr, output wdata, input rdata);
  modport bank   (input rd, input wr, input addr, input wdata, output rdata);
endinterface

// [design/pms_mdio_engine.sv]
// Serial management frame engine: decodes read and write frames.
// Assumes MDC well below a quarter of the core clock; pins are asynchronous.
`timescale 1ns/1ps
module pms_mdio_engine
  import pms_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = PMS_PHY_ADDR_DEF
)
(
  input  wire logic    mclk_i,
  input  wire logic    arst_n_i,
  input  wire logic    mdc_i,
  input  wire logic    mdio_i,
  output logic         mdio_o,
  output logic         mdio_oe_o,
  pms_mgmt_if.engine   req
);

  typedef struct packed {
    logic [2:0]          mdc_s;
    logic [1:0]          dat_s;
    pms_frame_state_type state;
    logic [5:0]          ones;
    logic [4:0]          cnt;
    logic [17:0]         sh;
    logic [15:0]         rd_sh;
    logic                rd;
    logic                wr;
    logic [4:0]          addr;
    logic [15:0]         wdata;
    logic                o;
    logic                oe;
  } pms_eng_type;

  pms_eng_type s_q;
  pms_eng_type s_d;
  logic        rise;
  logic        bit_in;
  logic [17:0] sh_nx;

  // ----------------------------------------------------------------------
  // Frame decoding
  // ----------------------------------------------------------------------
  always_comb
  begin
    s_d         = s_q;
    s_d.mdc_s   = {s_q.mdc_s[1:0], mdc_i};
    s_d.dat_s   = {s_q.dat_s[0], mdio_i};
    s_d.rd      = 1'b0;
    s_d.wr      = 1'b0;
    rise        = s_q.mdc_s[1] & ~s_q.mdc_s[2];
    bit_in      = s_q.dat_s[1];
    sh_nx       = {s_q.sh[16:0], bit_in};
    // Capture before the window pointer steps on
    if (s_q.rd)
    begin
      s_d.rd_sh = req.rdata;
    end
    if (rise)
    begin
      s_d.sh = sh_nx;
      case (s_q.state)
        PMS_S_PRE:
        begin
          if (bit_in)
          begin
            if (s_q.ones != PMS_PREAMBLE_CNT)
            begin
              s_d.ones = s_q.ones + 6'h01;
            end
          end
          else if (s_q.ones == PMS_PREAMBLE_CNT)
          begin
            s_d.state = PMS_S_HDR;
            s_d.cnt   = 5'h00;
          end
          else
          begin
            s_d.ones = 6'h00;
          end
        end
        PMS_S_HDR:
        begin
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == PMS_HDR_LAST)
          begin
            s_d.cnt   = 5'h00;
            s_d.ones  = 6'h00;
            s_d.state = PMS_S_PRE;
            s_d.addr  = sh_nx[4:0];
            if (sh_nx[12] && sh_nx[9:5] == PHY_ADDR)
            begin
              if (sh_nx[11:10] == PMS_OP_READ)
              begin
                s_d.state = PMS_S_RD;
                s_d.rd    = 1'b1;
              end
              else if (sh_nx[11:10] == PMS_OP_WRITE)
              begin
                s_d.state = PMS_S_WR;
              end
            end
          end
        end
        PMS_S_RD:
        begin
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == 5'h00)
          begin
            s_d.oe = 1'b1;
            s_d.o  = 1'b0;
          end
          else if (s_q.cnt == PMS_RD_LAST)
          begin
            s_d.oe    = 1'b0;
            s_d.o     = 1'b0;
            s_d.state = PMS_S_PRE;
          end
          else
          begin
            s_d.o     = s_q.rd_sh[15];
            s_d.rd_sh = {s_q.rd_sh[14:0], 1'b0};
          end
        end
        PMS_S_WR:
        begin
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == PMS_WR_LAST)
          begin
            s_d.wr    = 1'b1;
            s_d.wdata = sh_nx[15:0];
            s_d.state = PMS_S_PRE;
          end
        end
        default:
        begin
          s_d.state = PMS_S_PRE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign req.rd    = s_q.rd;
  assign req.wr    = s_q.wr;
  assign req.addr  = s_q.addr;
  assign req.wdata = s_q.wdata;
  assign mdio_o    = s_q.o;
  assign mdio_oe_o = s_q.oe;

endmodule

// [design/pms_phy_mgmt.sv]
// Management register space of a 10/100 transceiver with indirect spaces.
// Assumes straps and serial pins are asynchronous; negotiation on mclk_i.
`timescale 1ns/1ps
module pms_phy_mgmt
  import pms_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = PMS_PHY_ADDR_DEF
)
(
  input  wire logic        mclk_i,
  input  wire logic        arst_n_i,
  input  wire logic        mdc_i,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe_o,
  input  wire logic        speed_strap_i,
  input  wire logic        nway_strap_i,
  input  wire logic        iso_strap_i,
  input  wire logic        duplex_strap_i,
  input  wire logic        an_speed_100_i,
  input  wire logic        an_full_duplex_i,
  input  wire logic [15:0] lp_eee_adv_i,
  output logic             speed_100_o,
  output logic             full_duplex_o,
  output logic             loopback_o,
  output logic             power_down_o,
  output logic             isolate_o,
  output logic             col_test_o,
  output logic             an_enable_o,
  output logic             an_restart_o,
  output logic             soft_reset_o,
  output logic [15:0]      eee_adv_o
);

  typedef struct packed {
    logic [1:0]                       sp_s;
    logic [1:0]                       nw_s;
    logic [1:0]                       is_s;
    logic [1:0]                       du_s;
    logic [1:0]                       load;
    logic [15:0]                      basic;
    logic [PMS_STD_REGS-1:0][15:0]    std;
    logic [15:0]                      mmd_ctl;
    logic [15:0]                      mmd_adr;
    logic [15:0]                      eee_adv;
    logic [PMS_WOL_WORDS-1:0][15:0]   wol;
    logic                             spd;
    logic                             dup;
    logic                             anr;
    logic                             srst;
  } pms_bank_type;

  pms_bank_type b_q;
  pms_bank_type b_d;
  pms_mgmt_if   mif ();
  logic         mmd_inc;

  pms_mdio_engine #(
    .PHY_ADDR (PHY_ADDR)
  ) u_engine (
    .mclk_i    (mclk_i),
    .arst_n_i  (arst_n_i),
    .mdc_i     (mdc_i),
    .mdio_i    (mdio_i),
    .mdio_o    (mdio_o),
    .mdio_oe_o (mdio_oe_o),
    .req       (mif.engine)
  );

  // ----------------------------------------------------------------------
  // Indirect space read decode
  // ----------------------------------------------------------------------
  function automatic logic [15:0] mmd_read(input pms_bank_type b,
                                           input logic [15:0]  lp);
    logic [15:0] r;
    r = 16'h0000;
    if (b.mmd_ctl[4:0] == PMS_DEV_EEE && b.mmd_adr == PMS_EEE_ADV)
    begin
      r = b.eee_adv;
    end
    else if (b.mmd_ctl[4:0] == PMS_DEV_EEE && b.mmd_adr == PMS_EEE_LP_ADV)
    begin
      r = lp;
    end
    else if (b.mmd_ctl[4:0] == PMS_DEV_WOL && b.mmd_adr <= PMS_WOL_LAST)
    begin
      r = b.wol[b.mmd_adr[4:0]];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------------
  always_comb
  begin
    case (mif.addr)
      PMS_REG_BASIC:   mif.rdata = b_q.basic;
      PMS_REG_MMD_CTL: mif.rdata = b_q.mmd_ctl;
      PMS_REG_MMD_DAT:
      begin
        if (b_q.mmd_ctl[PMS_MMD_FN_HI:PMS_MMD_FN_LO] == PMS_FN_ADDR)
        begin
          mif.rdata = b_q.mmd_adr;
        end
        else
        begin
          mif.rdata = mmd_read(b_q, lp_eee_adv_i);
        end
      end
      default:         mif.rdata = b_q.std[mif.addr];
    endcase
  end

  // ----------------------------------------------------------------------
  // Register update
  // ----------------------------------------------------------------------
  always_comb
  begin
    b_d      = b_q;
    b_d.sp_s = {b_q.sp_s[0], speed_strap_i};
    b_d.nw_s = {b_q.nw_s[0], nway_strap_i};
    b_d.is_s = {b_q.is_s[0], iso_strap_i};
    b_d.du_s = {b_q.du_s[0], duplex_strap_i};
    b_d.anr  = 1'b0;
    b_d.srst = 1'b0;
    mmd_inc  = 1'b0;
    if (b_q.load != 2'h0)
    begin
      b_d.load                = b_q.load - 2'h1;
      b_d.basic               = PMS_BASIC_RST;
      b_d.basic[PMS_B_SPEED]  = b_q.sp_s[1];
      b_d.basic[PMS_B_ANEN]   = b_q.nw_s[1];
      b_d.basic[PMS_B_ISO]    = b_q.is_s[1];
      b_d.basic[PMS_B_DUPLEX] = ~b_q.du_s[1];
      b_d.std                 = '0;
      b_d.mmd_ctl             = 16'h0000;
      b_d.mmd_adr             = 16'h0000;
      b_d.eee_adv             = PMS_EEE_ADV_RST;
      b_d.wol                 = '0;
    end
    else if (mif.wr)
    begin
      case (mif.addr)
        PMS_REG_BASIC:
        begin
          if (mif.wdata[PMS_B_RESET] && b_q.basic[PMS_B_PDOWN])
          begin
            b_d.basic[PMS_B_PDOWN] = 1'b0;
          end
          else if (mif.wdata[PMS_B_RESET])
          begin
            b_d.srst = 1'b1;
            b_d.load = PMS_LOAD_WAIT;
          end
          else
          begin
            b_d.basic = mif.wdata & PMS_BASIC_RW_MSK;
            b_d.anr   = mif.wdata[PMS_B_ANRST];
          end
        end
        PMS_REG_MMD_CTL: b_d.mmd_ctl = mif.wdata;
        PMS_REG_MMD_DAT:
        begin
          if (b_q.mmd_ctl[PMS_MMD_FN_HI:PMS_MMD_FN_LO] == PMS_FN_ADDR)
          begin
            b_d.mmd_adr = mif.wdata;
          end
          else
          begin
            mmd_inc = b_q.mmd_ctl[PMS_MMD_FN_HI];
            if (b_q.mmd_ctl[4:0] == PMS_DEV_EEE && b_q.mmd_adr == PMS_EEE_ADV)
            begin
              b_d.eee_adv = mif.wdata;
            end
            else if (b_q.mmd_ctl[4:0] == PMS_DEV_WOL && b_q.mmd_adr <= PMS_WOL_LAST)
            begin
              b_d.wol[b_q.mmd_adr[4:0]] = mif.wdata;
            end
          end
        end
        default: b_d.std[mif.addr] = mif.wdata;
      endcase
    end
    else if (mif.rd && mif.addr == PMS_REG_MMD_DAT)
    begin
      mmd_inc = b_q.mmd_ctl[PMS_MMD_FN_HI:PMS_MMD_FN_LO] == PMS_FN_INC_RW;
    end
    if (mmd_inc)
    begin
      b_d.mmd_adr = b_q.mmd_adr + 16'h0001;
    end
    b_d.spd = b_q.basic[PMS_B_ANEN] ? an_speed_100_i : b_q.basic[PMS_B_SPEED];
    b_d.dup = b_q.basic[PMS_B_ANEN] ? an_full_duplex_i : b_q.basic[PMS_B_DUPLEX];
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      b_q      <= '0;
      b_q.load <= PMS_LOAD_WAIT;
    end
    else
    begin
      b_q <= b_d;
    end
  end

  assign speed_100_o   = b_q.spd;
  assign full_duplex_o = b_q.dup;
  assign loopback_o    = b_q.basic[PMS_B_LOOP];
  assign power_down_o  = b_q.basic[PMS_B_PDOWN];
  assign isolate_o     = b_q.basic[PMS_B_ISO];
  assign col_test_o    = b_q.basic[PMS_B_COLTEST];
  assign an_enable_o   = b_q.basic[PMS_B_ANEN];
  assign an_restart_o  = b_q.anr;
  assign soft_reset_o  = b_q.srst;
  assign eee_adv_o     = b_q.eee_adv;

endmodule

// [testbench/pms_phy_mgmt_props.sv]
// Port checker of the management register space.
// Assumes the top module's ports only; bound after the module.
`timescale 1ns/1ps
module pms_phy_mgmt_props
(
  input wire logic        mclk_i,
  input wire logic        arst_n_i,
  input wire logic        mdio_o,
  input wire logic        mdio_oe_o,
  input wire logic        nway_strap_i,
  input wire logic        iso_strap_i,
  input wire logic        an_speed_100_i,
  input wire logic        an_full_duplex_i,
  input wire logic        speed_100_o,
  input wire logic        full_duplex_o,
  input wire logic        loopback_o,
  input wire logic        power_down_o,
  input wire logic        col_test_o,
  input wire logic        an_enable_o,
  input wire logic        isolate_o,
  input wire logic        soft_reset_o,
  input wire logic [15:0] eee_adv_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  property p_spd_an;
    an_enable_o |=> speed_100_o == $past(an_speed_100_i);
  endproperty
  a_spd_an: assert property (p_spd_an) else $error("speed not from negotiation");
  property p_dup_an;
    an_enable_o |=> full_duplex_o == $past(an_full_duplex_i);
  endproperty
  a_dup_an: assert property (p_dup_an) else $error("duplex not from negotiation");
  property p_srst_pulse;
    soft_reset_o |=> !soft_reset_o;
  endproperty
  a_srst_pulse: assert property (p_srst_pulse) else $error("reset pulse too long");
  property p_srst_clear;
    soft_reset_o |-> ##[1:4] (!loopback_o && !power_down_o && !col_test_o
                              && eee_adv_o == 16'h0000);
  endproperty
  a_srst_clear: assert property (p_srst_clear) else $error("bits kept after reset");
  property p_srst_strap;
    soft_reset_o |-> ##5 (an_enable_o == nway_strap_i && isolate_o == iso_strap_i);
  endproperty
  a_srst_strap: assert property (p_srst_strap) else $error("straps not relatched");
  property p_ta_zero;
    $rose(mdio_oe_o) |-> !mdio_o;
  endproperty
  a_ta_zero: assert property (p_ta_zero) else $error("turnaround not zero");
  property p_oe_hold;
    $rose(mdio_oe_o) |-> mdio_oe_o[*8];
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("data line dropped early");
  property p_data_hold;
    mdio_oe_o && $changed(mdio_o) |=> $stable(mdio_o)[*7];
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("read bit too short");
endmodule

bind pms_phy_mgmt pms_phy_mgmt_props u_props (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
  .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .nway_strap_i(nway_strap_i),
  .iso_strap_i(iso_strap_i), .an_speed_100_i(an_speed_100_i),
  .an_full_duplex_i(an_full_duplex_i), .speed_100_o(speed_100_o),
  .full_duplex_o(full_duplex_o), .loopback_o(loopback_o), .power_down_o(power_down_o),
  .col_test_o(col_test_o), .an_enable_o(an_enable_o), .isolate_o(isolate_o),
  .soft_reset_o(soft_reset_o), .eee_adv_o(eee_adv_o));

// [testbench/pms_sta_model.sv]
// Station management model issuing serial read and write frames.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
module pms_sta_model
  import pms_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic md_wire_i,
  output logic      mdc_o,
  output logic      md_o,
  output logic      md_en_o
);
  initial
  begin
    mdc_o   = 1'b0;
    md_o    = 1'b1;
    md_en_o = 1'b0;
  end

  // One clock period of ten core cycles, sampled at the rise
  task automatic cyc(input logic b, output logic s);
    md_o = b;
    repeat (5) @(negedge mclk_i);
    s     = md_wire_i;
    mdc_o = 1'b1;
    repeat (5) @(negedge mclk_i);
    mdc_o = 1'b0;
  endtask

  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic        s;
    hdr     = {2'b01, op, pa, ra};
    md_en_o = 1'b1;
    repeat (32) cyc(1'b1, s);
    for (int i = 13; i >= 0; i--) cyc(hdr[i], s);
    md_en_o = (op == PMS_OP_WRITE);
    cyc(1'b1, s);
    cyc(1'b0, s);
    for (int i = 15; i >= 0; i--)
    begin
      cyc(wd[i], s);
      rd[i] = s;
    end
    md_en_o = 1'b0;
    cyc(1'b1, s);
  endtask
endmodule

// [testbench/tb_top.sv]
// Bench of the management register space driven by the station model.
// Assumes a 20 MHz core clock and straps held steady around resets.
`timescale 1ns/1ps
module tb_top
  import pms_pkg::*;
;
  logic        mclk, arst_n, mdc, md_drv, md_en, mdio_o, mdio_oe;
  logic        s_spd, s_nway, s_iso, s_dup, an_spd, an_fd;
  logic        spd, fd, lpbk, pdn, iso, col, anen, anrst, srst;
  logic [15:0] lp_adv, eee_adv, rv;
  int          err_count = 0;
  int          check_count = 0;
  int          srst_seen = 0;
  int          anr_seen = 0;
  wire         mdio_w = mdio_oe ? mdio_o : (md_en ? md_drv : 1'b1);

  pms_phy_mgmt uut (.mclk_i(mclk), .arst_n_i(arst_n), .mdc_i(mdc), .mdio_i(mdio_w),
    .mdio_o(mdio_o), .mdio_oe_o(mdio_oe), .speed_strap_i(s_spd), .nway_strap_i(s_nway),
    .iso_strap_i(s_iso), .duplex_strap_i(s_dup), .an_speed_100_i(an_spd),
    .an_full_duplex_i(an_fd), .lp_eee_adv_i(lp_adv), .speed_100_o(spd),
    .full_duplex_o(fd), .loopback_o(lpbk), .power_down_o(pdn), .isolate_o(iso),
    .col_test_o(col), .an_enable_o(anen), .an_restart_o(anrst), .soft_reset_o(srst),
    .eee_adv_o(eee_adv));
  pms_sta_model sta (.mclk_i(mclk), .md_wire_i(mdio_w), .mdc_o(mdc), .md_o(md_drv),
    .md_en_o(md_en));

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  always @(negedge mclk)
  begin
    if (srst) srst_seen++;
    if (anrst) anr_seen++;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    sta.xfer(PMS_OP_WRITE, PMS_PHY_ADDR_DEF, ra, d, rv);
  endtask
  task automatic rd(input logic [4:0] ra);
    sta.xfer(PMS_OP_READ, PMS_PHY_ADDR_DEF, ra, 16'h0000, rv);
  endtask
  task automatic mmd(input logic [1:0] fn, input logic [4:0] dev, input logic [15:0] a);
    wr(PMS_REG_MMD_CTL, {PMS_FN_ADDR, 9'h000, dev});
    wr(PMS_REG_MMD_DAT, a);
    wr(PMS_REG_MMD_CTL, {fn, 9'h000, dev});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_speed();
    rd(PMS_REG_BASIC);
    chk("basic_default", rv, 16'h2000);
    wr(PMS_REG_BASIC, 16'h0100);
    chk("speed_10", spd, 1'b0);
    chk("duplex_manual", fd, 1'b1);
    an_spd = 1'b1;
    an_fd  = 1'b0;
    wr(PMS_REG_BASIC, 16'h1100);
    chk("speed_an", spd, 1'b1);
    chk("duplex_an", fd, 1'b0);
    rd(PMS_REG_BASIC);
    chk("basic_an", rv, 16'h1100);
    an_spd = 1'b0;
    wr(PMS_REG_BASIC, 16'h2000);
    chk("speed_100", spd, 1'b1);
    wr(PMS_REG_BASIC, 16'h2200);
    chk("an_restart", 16'(anr_seen), 16'h0001);
    rd(PMS_REG_BASIC);
    chk("restart_sc", rv, 16'h2000);
    $display("test speed done");
  endtask

  task automatic t_std();
    logic [4:0] ta [5] = '{5'h01, 5'h0f, 5'h10, 5'h19, 5'h1f};
    foreach (ta[i]) wr(ta[i], {ta[i], 11'h2a5});
    foreach (ta[i])
    begin
      rd(ta[i]);
      chk("std_word", rv, {ta[i], 11'h2a5});
    end
    $display("test standard space done");
  endtask

  task automatic t_mmd();
    mmd(PMS_FN_INC_WR, PMS_DEV_WOL, PMS_WOL_PKT_LO);
    for (int i = 1; i <= 27; i++) wr(PMS_REG_MMD_DAT, 16'hb000 + 16'(i));
    mmd(PMS_FN_INC_RW, PMS_DEV_WOL, PMS_WOL_PKT_LO);
    for (int i = 1; i <= 27; i++)
    begin
      rd(PMS_REG_MMD_DAT);
      chk("wake_word", rv, 16'hb000 + 16'(i));
    end
    mmd(PMS_FN_DATA, PMS_DEV_EEE, PMS_EEE_ADV);
    wr(PMS_REG_MMD_DAT, 16'h0006);
    chk("eee_adv_out", eee_adv, 16'h0006);
    rd(PMS_REG_MMD_DAT);
    chk("eee_adv_rd", rv, 16'h0006);
    mmd(PMS_FN_DATA, PMS_DEV_EEE, PMS_EEE_LP_ADV);
    wr(PMS_REG_MMD_DAT, 16'hffff);
    rd(PMS_REG_MMD_DAT);
    chk("eee_lp_adv", rv, lp_adv);
    rd(5'h19);
    chk("std_apart", rv, {5'h19, 11'h2a5});
    $display("test indirect spaces done");
  endtask

  task automatic t_refuse();
    sta.xfer(PMS_OP_WRITE, PMS_PHY_ADDR_DEF + 5'h01, 5'h10, 16'h1234, rv);
    rd(5'h10);
    chk("foreign_write", rv, {5'h10, 11'h2a5});
    sta.xfer(PMS_OP_READ, PMS_PHY_ADDR_DEF + 5'h01, 5'h10, 16'h0000, rv);
    chk("foreign_read", rv, 16'hffff);
    $display("test refusal done");
  endtask

  task automatic t_sreset();
    wr(PMS_REG_BASIC, 16'h0800);
    chk("power_down", pdn, 1'b1);
    wr(PMS_REG_BASIC, 16'h8000);
    chk("pd_exit", pdn, 1'b0);
    chk("no_reset", 16'(srst_seen), 16'h0000);
    wr(PMS_REG_BASIC, 16'h4080);
    chk("loopback", lpbk, 1'b1);
    s_dup = 1'b0;
    wr(PMS_REG_BASIC, 16'h8000);
    chk("reset_pulses", 16'(srst_seen), 16'h0001);
    chk("loop_clear", lpbk, 1'b0);
    chk("eee_clear", eee_adv, 16'h0000);
    rd(PMS_REG_BASIC);
    chk("basic_relatch", rv, 16'h2100);
    rd(5'h10);
    chk("std_clear", rv, 16'h0000);
    $display("test software reset done");
  endtask

  initial
  begin
    #(90000 * 50);
    err_count++;
    tally_and_finish();
  end

  initial
  begin
    arst_n = 1'b0;
    s_spd  = 1'b1;
    s_nway = 1'b0;
    s_iso  = 1'b0;
    s_dup  = 1'b1;
    an_spd = 1'b0;
    an_fd  = 1'b1;
    lp_adv = 16'h0042;
    repeat (3) @(negedge mclk);
    arst_n = 1'b1;
    repeat (6) @(negedge mclk);
    t_speed();
    t_std();
    t_mmd();
    t_refuse();
    t_sreset();
    tally_and_finish();
  end
endmodule
